/* File: hw/dstfb_pkg.sv */
// Constants for the daylight-saving fall-back hour repeat block.
// Assumes a byte-addressed Avalon-MM slave port with 32-bit data.
package dstfb_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_FALL_BACK = 6'h1C;
  localparam logic [5:0] OFS_CONTROL = 6'h20;
  localparam logic [5:0] OFS_STATUS = 6'h24;
  // ----------------------------------------------------------------
  // Fall-back match fields
  // ----------------------------------------------------------------
  localparam int MER_BIT = 31;
  localparam int HOUR_LSB = 24;
  localparam int WEEK_LSB = 16;
  localparam int WDAY_LSB = 8;
  localparam logic [31:0] FB_RW_MASK = 32'hFF07_07FF;
  localparam logic [31:0] FB_RESET = 32'h0000_0000;
  localparam logic [2:0] WEEK_LAST = 3'h5;
  // ----------------------------------------------------------------
  // Control and status bits
  // ----------------------------------------------------------------
  localparam int CTL_STE = 0;
  localparam int CTL_BIN = 1;
  localparam int CTL_H12 = 2;
  localparam int CTL_HALT = 3;
  localparam int CTL_RUN = 4;
  localparam int CTL_SRST = 5;
  localparam logic [4:0] CTL_RESET = 5'h00;
  localparam int STS_ARMED = 0;
  localparam int STS_WEEK_LSB = 4;
  localparam int STS_LAST = 7;
  // ----------------------------------------------------------------
  // Calendar figures
  // ----------------------------------------------------------------
  localparam logic [7:0] DAYS_PER_WEEK = 8'h07;
  localparam logic [7:0] FEB = 8'h02;
  localparam logic [7:0] APR = 8'h04;
  localparam logic [7:0] JUN = 8'h06;
  localparam logic [7:0] SEP = 8'h09;
  localparam logic [7:0] NOV = 8'h0B;
endpackage

/* File: hw/dstfb_top.sv */
// Daylight-saving fall-back match register and hour-carry gate.
// Assumes the calendar counters and the hour carry come from logic on CLOCK.
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module dstfb_top (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [5:0] ADDRESS,
  input wire logic [3:0] BYTEENABLE,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic [7:0] HOURS,
  input wire logic [7:0] WEEKDAY,
  input wire logic [7:0] DATE,
  input wire logic [7:0] MONTH,
  input wire logic LEAP_YEAR,
  input wire logic HOUR_CARRY,
  output logic HOUR_ADVANCE,
  output logic SUMMER_TIME_ENABLE,
  output logic BINARY_FORMAT_SELECT,
  output logic HOUR_MODE_12,
  output logic UPDATE_HALT,
  output logic BLOCK_ENABLE,
  output logic BLOCK_RESET
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
    logic [7:0] t;
    t = {1'b0, v[7:4], 3'b000} + {3'b000, v[7:4], 1'b0} + {4'h0, v[3:0]};
    to_bin = bin ? v : t;
  endfunction

  logic [31:0] fb_ff;
  logic [6:0] cmp_hour_ff;
  logic cmp_mer_ff;
  logic cmp_h12_ff;
  logic [7:0] cmp_month_ff;
  logic [4:0] ctl_ff;
  logic srst_ff;
  logic armed_ff;
  logic [2:0] week_ff;
  logic last_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic adv_ff;
  logic req;
  logic wr_go;
  logic [31:0] be_mask;
  logic [31:0] nxt_fb;
  logic [7:0] date_bin;
  logic [7:0] month_bin;
  logic [7:0] dim;
  logic [2:0] nxt_week;
  logic nxt_last;
  logic fields_match;
  logic run;
  logic fire;
  logic [7:0] hour_wr_bin;
  logic [7:0] hour_now_bin;

  assign req = READ | WRITE;
  assign wr_go = WRITE & ~wait_ff;
  assign be_mask = {{8{BYTEENABLE[3]}}, {8{BYTEENABLE[2]}}, {8{BYTEENABLE[1]}},
                    {8{BYTEENABLE[0]}}};
  assign run = ctl_ff[dstfb_pkg::CTL_RUN] & ~ctl_ff[dstfb_pkg::CTL_HALT];

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle: data is latched while waiting, write lands on release
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wait_ff <= 1'b1;
    end else if (req && wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_ff <= 32'h0000_0000;
    end else if (READ && wait_ff) begin
      unique case (ADDRESS)
        dstfb_pkg::OFS_FALL_BACK: rdata_ff <= fb_ff & dstfb_pkg::FB_RW_MASK;
        dstfb_pkg::OFS_CONTROL: rdata_ff <= {26'h0, srst_ff, ctl_ff};
        dstfb_pkg::OFS_STATUS: rdata_ff <= {24'h0, last_ff, week_ff, 3'h0, armed_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fall-back register
  // ----------------------------------------------------------------
  assign nxt_fb = (fb_ff & ~be_mask) | (WRITEDATA & be_mask & dstfb_pkg::FB_RW_MASK);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      fb_ff <= dstfb_pkg::FB_RESET;
    end else if (srst_ff) begin
      fb_ff <= dstfb_pkg::FB_RESET;
    end else if (wr_go && ADDRESS == dstfb_pkg::OFS_FALL_BACK) begin
      fb_ff <= nxt_fb;
    end
  end

  // Compare copies are taken per lane in the formats of write time
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cmp_hour_ff <= 7'h00;
      cmp_mer_ff <= 1'b0;
      cmp_h12_ff <= 1'b0;
      cmp_month_ff <= 8'h00;
    end else if (srst_ff) begin
      cmp_hour_ff <= 7'h00;
      cmp_mer_ff <= 1'b0;
      cmp_h12_ff <= 1'b0;
      cmp_month_ff <= 8'h00;
    end else if (wr_go && ADDRESS == dstfb_pkg::OFS_FALL_BACK) begin
      if (BYTEENABLE[3]) begin
        cmp_hour_ff <= hour_wr_bin[6:0];
        cmp_mer_ff <= WRITEDATA[dstfb_pkg::MER_BIT];
        cmp_h12_ff <= ctl_ff[dstfb_pkg::CTL_H12];
      end
      if (BYTEENABLE[0]) begin
        cmp_month_ff <= to_bin(WRITEDATA[7:0], ctl_ff[dstfb_pkg::CTL_BIN]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register and soft reset
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctl_ff <= dstfb_pkg::CTL_RESET;
    end else if (srst_ff) begin
      ctl_ff <= dstfb_pkg::CTL_RESET;
    end else if (wr_go && ADDRESS == dstfb_pkg::OFS_CONTROL && BYTEENABLE[0]) begin
      ctl_ff <= WRITEDATA[4:0];
    end
  end

  // Self-clearing after the single reset cycle it causes
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      srst_ff <= 1'b0;
    end else if (srst_ff) begin
      srst_ff <= 1'b0;
    end else if (wr_go && ADDRESS == dstfb_pkg::OFS_CONTROL && BYTEENABLE[0]) begin
      srst_ff <= WRITEDATA[dstfb_pkg::CTL_SRST];
    end
  end

  // ----------------------------------------------------------------
  // Week of month
  // ----------------------------------------------------------------
  assign date_bin = to_bin(DATE, ctl_ff[dstfb_pkg::CTL_BIN]);
  assign month_bin = to_bin(MONTH, ctl_ff[dstfb_pkg::CTL_BIN]);
  assign hour_wr_bin = to_bin({1'b0, WRITEDATA[30:24]}, ctl_ff[dstfb_pkg::CTL_BIN]);
  assign hour_now_bin = to_bin({1'b0, HOURS[6:0]}, ctl_ff[dstfb_pkg::CTL_BIN]);

  always_comb begin
    if (month_bin == dstfb_pkg::FEB) begin
      dim = LEAP_YEAR ? 8'h1D : 8'h1C;
    end else if (month_bin == dstfb_pkg::APR || month_bin == dstfb_pkg::JUN ||
                 month_bin == dstfb_pkg::SEP || month_bin == dstfb_pkg::NOV) begin
      dim = 8'h1E;
    end else begin
      dim = 8'h1F;
    end
    if (date_bin <= dstfb_pkg::DAYS_PER_WEEK) begin
      nxt_week = 3'h1;
    end else if (date_bin <= 8'(dstfb_pkg::DAYS_PER_WEEK * 2)) begin
      nxt_week = 3'h2;
    end else if (date_bin <= 8'(dstfb_pkg::DAYS_PER_WEEK * 3)) begin
      nxt_week = 3'h3;
    end else if (date_bin <= 8'(dstfb_pkg::DAYS_PER_WEEK * 4)) begin
      nxt_week = 3'h4;
    end else begin
      nxt_week = dstfb_pkg::WEEK_LAST;
    end
    nxt_last = (9'(date_bin) + 9'(dstfb_pkg::DAYS_PER_WEEK)) > 9'(dim);
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      week_ff <= 3'h1;
      last_ff <= 1'b0;
    end else begin
      week_ff <= nxt_week;
      last_ff <= nxt_last;
    end
  end

  // ----------------------------------------------------------------
  // Match and hour-carry gate
  // ----------------------------------------------------------------
  // Fields are compared as stored: a zero field never acts as don't-care
  always_comb begin
    fields_match = 1'b1;
    if (hour_now_bin[6:0] != cmp_hour_ff) begin
      fields_match = 1'b0;
    end
    if (cmp_h12_ff && HOURS[7] != cmp_mer_ff) begin
      fields_match = 1'b0;
    end
    if (WEEKDAY[2:0] != fb_ff[10:8]) begin
      fields_match = 1'b0;
    end
    if (month_bin != cmp_month_ff) begin
      fields_match = 1'b0;
    end
    if (fb_ff[18:16] == dstfb_pkg::WEEK_LAST) begin
      if (!last_ff) begin
        fields_match = 1'b0;
      end
    end else if (fb_ff[18:16] != week_ff) begin
      fields_match = 1'b0;
    end
  end

  assign fire = HOUR_CARRY & run & ctl_ff[dstfb_pkg::CTL_STE] & armed_ff & fields_match;

  // Disarmed for exactly the repeated hour, ended by its own carry
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      armed_ff <= 1'b1;
    end else if (srst_ff) begin
      armed_ff <= 1'b1;
    end else if (fire) begin
      armed_ff <= 1'b0;
    end else if (HOUR_CARRY && run) begin
      armed_ff <= 1'b1;
    end
  end

  // Gate costs one cycle of carry latency so the output is registered
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      adv_ff <= 1'b0;
    end else begin
      adv_ff <= HOUR_CARRY & run & ~fire;
    end
  end

  assign READDATA = rdata_ff;
  assign WAITREQUEST = wait_ff;
  assign HOUR_ADVANCE = adv_ff;
  assign SUMMER_TIME_ENABLE = ctl_ff[dstfb_pkg::CTL_STE];
  assign BINARY_FORMAT_SELECT = ctl_ff[dstfb_pkg::CTL_BIN];
  assign HOUR_MODE_12 = ctl_ff[dstfb_pkg::CTL_H12];
  assign UPDATE_HALT = ctl_ff[dstfb_pkg::CTL_HALT];
  assign BLOCK_ENABLE = ctl_ff[dstfb_pkg::CTL_RUN];
  assign BLOCK_RESET = srst_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  sequence fire_s;
    fire ##1 !HOUR_ADVANCE;
  endsequence
  sequence wait_s;
    !WAITREQUEST ##1 WAITREQUEST;
  endsequence

  swallow_carry_a: assert property (fire |-> fire_s)
    else $error("Matched carry was passed on");
  pass_carry_a: assert property (HOUR_CARRY && run && !fire |=> HOUR_ADVANCE)
    else $error("Unmatched carry was lost");
  disarm_fire_a: assert property (fire && !srst_ff |=> !armed_ff)
    else $error("Match not disarmed after firing");
  rearm_carry_a: assert property (!armed_ff && HOUR_CARRY && run && !srst_ff |=> armed_ff)
    else $error("Match not rearmed after repeated hour");
  no_refire_a: assert property (fire |=> !fire)
    else $error("Match fired on consecutive cycles");
  stopped_idle_a: assert property (!run |=> !HOUR_ADVANCE && !$past(fire))
    else $error("Activity while block stopped");
  reserved_zero_a: assert property (!WAITREQUEST |-> READDATA[23:19] == 5'h00 &&
                                    READDATA[15:11] == 5'h00)
    else $error("Reserved bits read nonzero");
  soft_clear_a: assert property (srst_ff |=> !srst_ff &&
                                 fb_ff == dstfb_pkg::FB_RESET && ctl_ff == dstfb_pkg::CTL_RESET)
    else $error("Soft reset did not clear block");
  byte_write_a: assert property (wr_go && !srst_ff &&
                                 ADDRESS == dstfb_pkg::OFS_FALL_BACK && BYTEENABLE == 4'h1
                                 |=> fb_ff[31:8] == $past(fb_ff[31:8]) &&
                                 fb_ff[7:0] == $past(WRITEDATA[7:0]))
    else $error("Byte write disturbed other lanes");
  // Any cycle without a fall-back write or soft reset, format changes included, must leave the hour and month copies
  format_hold_a: assert property (!srst_ff &&
                                  !(wr_go && ADDRESS == dstfb_pkg::OFS_FALL_BACK)
                                  |=> $stable(cmp_hour_ff) && $stable(cmp_month_ff))
    else $error("Stored compare changed with format");
  wait_release_a: assert property (req && WAITREQUEST |=> wait_s)
    else $error("Bus answer not one wait cycle");
endmodule // dstfb_top

/* File: bench/dstfb_top_tb.sv */
// Self-checking bench for the fall-back match register and hour-carry gate.
// Assumes dstfb_top and dstfb_pkg; the bench drives every port itself.
module dstfb_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] address = 6'h00;
  logic [3:0] byteenable = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic [7:0] hours = 8'h00;
  logic [7:0] weekday = 8'h00;
  logic [7:0] date = 8'h01;
  logic [7:0] month = 8'h01;
  logic hour_carry = 1'b0;
  logic leap_year = 1'b0;
  logic hour_advance, ste, bin, h12, halt, run, blk_rst;
  logic [31:0] rd;
  logic [31:0] exp_fb;
  int failures = 0;
  int n_compared = 0;
  // One field off in each entry: {hours, weekday, date, month}
  logic [31:0] miss_tbl [0:4] = '{32'h0101_1A0B, 32'h8201_1A0B, 32'h8101_0F0B,
                                  32'h8102_1A0B, 32'h8101_1A0A};

  dstfb_top i_dut (.CLOCK(clock), .RSTN(rstn), .ADDRESS(address), .BYTEENABLE(byteenable),
    .READ(read), .WRITE(write), .WRITEDATA(writedata), .READDATA(readdata),
    .WAITREQUEST(waitrequest), .HOURS(hours), .WEEKDAY(weekday), .DATE(date),
    .MONTH(month), .LEAP_YEAR(leap_year), .HOUR_CARRY(hour_carry), .HOUR_ADVANCE(hour_advance),
    .SUMMER_TIME_ENABLE(ste), .BINARY_FORMAT_SELECT(bin), .HOUR_MODE_12(h12),
    .UPDATE_HALT(halt), .BLOCK_ENABLE(run), .BLOCK_RESET(blk_rst));

  initial begin
    forever #12.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Compare, bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low, releases it at once and idles one more edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    byteenable <= be;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    rd = readdata;
    if (n >= 40) cmp1(waitrequest, 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 4'hF, 32'h0000_0000);
    cmp32(rd, exp);
  endtask

  // Week count follows DATE one cycle late, so let the inputs settle
  task automatic setcal(input logic [31:0] c);
    {hours, weekday, date, month} <= c;
    repeat (3) @(posedge clock);
  endtask

  task automatic carry(input logic exp);
    hour_carry <= 1'b1;
    @(posedge clock);
    hour_carry <= 1'b0;
    #1;
    cmp1(hour_advance, exp);
    @(posedge clock);
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    cmp1(waitrequest, 1'b1);
    chk(dstfb_pkg::OFS_FALL_BACK, dstfb_pkg::FB_RESET);
    chk(dstfb_pkg::OFS_CONTROL, 32'h0000_0000);
    $display("test reset done");
    bus(1'b1, dstfb_pkg::OFS_FALL_BACK, 4'hF, 32'hFFFF_FFFF);
    chk(dstfb_pkg::OFS_FALL_BACK, dstfb_pkg::FB_RW_MASK);
    bus(1'b1, 6'h3C, 4'hF, 32'hFFFF_FFFF);
    chk(6'h3C, 32'h0000_0000);
    bus(1'b1, dstfb_pkg::OFS_FALL_BACK, 4'hF, 32'h0000_0000);
    exp_fb = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, dstfb_pkg::OFS_FALL_BACK, 4'h1 << i, 32'hA5A5_A5A5);
      exp_fb = exp_fb | (32'hA5A5_A5A5 & dstfb_pkg::FB_RW_MASK & (32'hFF << (8 * i)));
      chk(dstfb_pkg::OFS_FALL_BACK, exp_fb);
    end
    $display("test byte lanes done");
    // Program while summer time is off, then switch it on
    bus(1'b1, dstfb_pkg::OFS_CONTROL, 4'hF, 32'h0000_0016);
    bus(1'b1, dstfb_pkg::OFS_FALL_BACK, 4'hF, 32'h8104_010B);
    bus(1'b1, dstfb_pkg::OFS_CONTROL, 4'hF, 32'h0000_0017);
    cmp32({27'h0, run, halt, h12, bin, ste}, 32'h0000_0017);
    setcal(32'h8101_1A0B);
    chk(dstfb_pkg::OFS_STATUS, 32'h0000_00C1);
    for (int i = 0; i < 5; i++) begin
      setcal(miss_tbl[i]);
      carry(1'b1);
    end
    setcal(32'h8101_1A0B);
    carry(1'b0);
    chk(dstfb_pkg::OFS_STATUS, 32'h0000_00C0);
    carry(1'b1);
    chk(dstfb_pkg::OFS_STATUS, 32'h0000_00C1);
    $display("test fall-back match done");
    setcal(32'h0501_1A0B);
    bus(1'b1, dstfb_pkg::OFS_CONTROL, 4'hF, 32'h0000_001F);
    carry(1'b0);
    bus(1'b1, dstfb_pkg::OFS_CONTROL, 4'hF, 32'h0000_0007);
    carry(1'b0);
    bus(1'b1, dstfb_pkg::OFS_CONTROL, 4'hF, 32'h0000_0017);
    carry(1'b1);
    bus(1'b1, dstfb_pkg::OFS_FALL_BACK, 4'hF, 32'h8105_010B);
    setcal(32'h8101_1A0B);
    carry(1'b0);
    $display("test run, halt and last week done");
    // February 22nd is in the last week only in a common year
    setcal(32'h0501_1602);
    chk(dstfb_pkg::OFS_STATUS, 32'h0000_00C0);
    leap_year <= 1'b1;
    setcal(32'h0501_1602);
    chk(dstfb_pkg::OFS_STATUS, 32'h0000_0040);
    // Written in BCD with summer time off, matched later in binary
    bus(1'b1, dstfb_pkg::OFS_CONTROL, 4'hF, 32'h0000_0014);
    carry(1'b1);
    bus(1'b1, dstfb_pkg::OFS_FALL_BACK, 4'hF, 32'h9204_0111);
    bus(1'b1, dstfb_pkg::OFS_CONTROL, 4'hF, 32'h0000_0017);
    setcal(32'h8C01_1A0B);
    carry(1'b0);
    $display("test leap year and format hold done");
    bus(1'b1, dstfb_pkg::OFS_CONTROL, 4'hF, 32'h0000_0020);
    exp_fb = 32'h0000_0000;
    for (int n = 0; n < 8 && exp_fb == 32'h0000_0000; n++) begin
      if (blk_rst === 1'b1) exp_fb = 32'h0000_0001;
      else @(posedge clock);
    end
    cmp32(exp_fb, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk(dstfb_pkg::OFS_FALL_BACK, dstfb_pkg::FB_RESET);
    chk(dstfb_pkg::OFS_CONTROL, 32'h0000_0000);
    $display("test soft reset done");
    close_out();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    close_out();
  end
endmodule // dstfb_top_tb
